// file: rct_regs.svh
`ifndef RCT_REGS_SVH
`define RCT_REGS_SVH

// ==========================================================
// register map (byte addresses, word aligned)
`define RCT_ADDR_W 4
`define RCT_OFS_CAUSE_CTRL 4'h0
`define RCT_OFS_STATUS 4'h4

// ==========================================================
// reset_cause_control field positions
`define RCT_BIT_IRQ_PRIO 7
`define RCT_BIT_SW_BOR 6
`define RCT_BIT_SOFT_RST 4
`define RCT_BIT_WDT_EXP 3
`define RCT_BIT_SLEEP 2
`define RCT_BIT_POR 1
`define RCT_BIT_BOR 0

// ==========================================================
// status register field positions
`define RCT_BIT_ST_BOR_ON 0
`define RCT_BIT_ST_SLEEPING 1
`define RCT_BIT_ST_PIN_LEVEL 2
`define RCT_BIT_ST_BOR_HOLD 3

// ==========================================================
// brownout mode encodings
`define RCT_BOR_MODE_OFF 2'h0
`define RCT_BOR_MODE_SW 2'h1
`define RCT_BOR_MODE_NOSLEEP 2'h2
`define RCT_BOR_MODE_ON 2'h3

// ==========================================================
// reset values of the priority bit and the cause flags
`define RCT_RST_IRQ_PRIO 1'h0
`define RCT_RST_CAUSE_SET 1'h1
`define RCT_RST_CAUSE_CLR 1'h0

// ==========================================================
// timing
`define RCT_CLK_MHZ 25
`define RCT_EXT_FILT_NS 200
`define RCT_EXT_FILT_CYC ((`RCT_EXT_FILT_NS * `RCT_CLK_MHZ + 999) / 1000)
`define RCT_BOR_MIN_NS 300
`define RCT_BOR_MIN_CYC ((`RCT_BOR_MIN_NS * `RCT_CLK_MHZ + 999) / 1000)
`define RCT_POWER_UP_TIMER_TICKS 2048
`define RCT_CNT_W 8
`define RCT_POWER_UP_TIMER_W 11

`endif

// file: rct_pkg.sv
`include "rct_regs.svh"

package rct_pkg;

   // ==========================================================
   // reset sequencing states
   typedef enum logic [1:0] {
      RS_POWERON,
      RS_BROWNOUT,
      RS_TIMER,
      RS_RUN
   } rct_state_t;

   // ==========================================================
   // core state
   typedef struct packed {
      rct_state_t state;
      logic irqPrio;
      logic swBor;
      logic softRstFlag;
      logic wdtExpFlag;
      logic sleepFlag;
      logic porFlag;
      logic borFlag;
      logic sleeping;
      logic evtReset;
      logic [`RCT_CNT_W-1:0] borCnt;
      logic [`RCT_POWER_UP_TIMER_W-1:0] pwrtCnt;
      logic ack;
      logic respErr;
      logic [31:0] readData;
   } rct_core_t;

   // ==========================================================
   // pin filter state
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [`RCT_CNT_W-1:0] lowCnt;
      logic resetReq;
   } rct_filt_t;

endpackage : rct_pkg

// file: rct_pin_if.sv
`timescale 1ns/1ps

interface rct_pin_if;
   logic pinRaw;
   logic pinSync;
   logic resetReq;

   modport filt (
      input pinRaw,
      output pinSync,
      output resetReq
   );

   modport core (
      output pinRaw,
      input pinSync,
      input resetReq
   );
endinterface : rct_pin_if

// file: rct_pin_filter.sv
`timescale 1ns/1ps
`include "rct_regs.svh"

module rct_pin_filter #(
   parameter logic [`RCT_CNT_W-1:0] FILT_CYC = `RCT_CNT_W'(`RCT_EXT_FILT_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pin side
   rct_pin_if.filt pin
);

   rct_pkg::rct_filt_t r;
   rct_pkg::rct_filt_t next_r;

   // ==========================================================
   // synchroniser and low-pulse filter
   always_comb
   begin
      next_r = r;
      next_r.sync1 = pin.pinRaw;
      next_r.sync2 = r.sync1;
      if (r.sync2)
      begin
         next_r.lowCnt = '0;
         next_r.resetReq = 1'b0;
      end
      else if (r.lowCnt >= FILT_CYC)
      begin
         next_r.resetReq = 1'b1;
      end
      else
      begin
         next_r.lowCnt = r.lowCnt + `RCT_CNT_W'(1);
      end
      if (!rst_b)
      begin
         next_r.sync1 = 1'b1;
         next_r.sync2 = 1'b1;
         next_r.lowCnt = '0;
         next_r.resetReq = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   assign pin.pinSync = r.sync2;
   assign pin.resetReq = r.resetReq;

endmodule : rct_pin_filter

// file: rct_reset_cause_tracking.sv
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "rct_regs.svh"


module rct_reset_cause_tracking #(
   parameter logic [`RCT_CNT_W-1:0] BOR_MIN_CYC = `RCT_CNT_W'(`RCT_BOR_MIN_CYC),
   parameter logic [`RCT_CNT_W-1:0] EXT_FILT_CYC = `RCT_CNT_W'(`RCT_EXT_FILT_CYC),
   parameter int POWER_UP_TIMER_TICKS = `RCT_POWER_UP_TIMER_TICKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [`RCT_ADDR_W-1:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   output logic [1:0] avsResponse,
   // external reset pin
   input wire logic extResetPinIn,
   output logic extResetPinOut,
   output logic extResetPinOe,
   output logic extResetPinPullup,
   output logic extResetPinDigital,
   // configuration word
   input wire logic [1:0] brownoutModeCfg,
   input wire logic [1:0] brownoutLevelCfg,
   input wire logic extResetPinEnable,
   input wire logic powerUpTimerEnable,
   // supply monitors
   input wire logic porPulse,
   input wire logic brownoutDetect,
   output logic brownoutDetectEnable,
   output logic [1:0] brownoutLevelSel,
   // cpu events
   input wire logic softResetInstr,
   input wire logic watchdogClearInstr,
   input wire logic sleepInstr,
   input wire logic watchdogTimeout,
   input wire logic wakeUp,
   input wire logic rcTick,
   // device side
   output logic deviceResetActive,
   output logic irqPriorityEnable
);

   rct_pkg::rct_core_t r;
   rct_pkg::rct_core_t next_r;

   rct_pin_if pinIf ();

   logic borOn;
   logic borTrip;
   logic extReset;
   logic powerOn;
   logic takeReq;
   logic doWrite;
   logic addrHit;

   // ==========================================================
   // brownout enable decode
   function automatic logic bor_enabled(
      input logic [1:0] mode,
      input logic swEn,
      input logic asleep
   );
      logic en;
      en = 1'b0;
      case (mode)
         `RCT_BOR_MODE_OFF: en = 1'b0;
         `RCT_BOR_MODE_SW: en = swEn;
         `RCT_BOR_MODE_NOSLEEP: en = ~asleep;
         `RCT_BOR_MODE_ON: en = 1'b1;
         default: en = 1'b0;
      endcase
      return en;
   endfunction : bor_enabled

   // ==========================================================
   // register address decode
   function automatic logic addr_mapped(
      input logic [`RCT_ADDR_W-1:0] addr
   );
      return (addr == `RCT_OFS_CAUSE_CTRL) || (addr == `RCT_OFS_STATUS);
   endfunction : addr_mapped

   // ==========================================================
   // register read mux
   function automatic logic [31:0] reg_read(
      input logic [`RCT_ADDR_W-1:0] addr,
      input rct_pkg::rct_core_t s,
      input logic [1:0] mode,
      input logic borEn,
      input logic pinLevel
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      case (addr)
         `RCT_OFS_CAUSE_CTRL:
         begin
            d[`RCT_BIT_IRQ_PRIO] = s.irqPrio;
            d[`RCT_BIT_SW_BOR] = (mode == `RCT_BOR_MODE_SW) & s.swBor;
            d[`RCT_BIT_SOFT_RST] = s.softRstFlag;
            d[`RCT_BIT_WDT_EXP] = s.wdtExpFlag;
            d[`RCT_BIT_SLEEP] = s.sleepFlag;
            d[`RCT_BIT_POR] = s.porFlag;
            d[`RCT_BIT_BOR] = s.borFlag;
         end
         `RCT_OFS_STATUS:
         begin
            d[`RCT_BIT_ST_BOR_ON] = borEn;
            d[`RCT_BIT_ST_SLEEPING] = s.sleeping;
            d[`RCT_BIT_ST_PIN_LEVEL] = pinLevel;
            d[`RCT_BIT_ST_BOR_HOLD] = (s.state == rct_pkg::RS_BROWNOUT);
         end
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction : reg_read

   // ==========================================================
   // pin synchroniser and filter
   assign pinIf.pinRaw = extResetPinIn;

   rct_pin_filter #(
      .FILT_CYC(EXT_FILT_CYC)
   ) rct_pin_filter_inst (
      .clk(clk),
      .rst_b(rst_b),
      .pin(pinIf.filt)
   );

   // ==========================================================
   // reset source combination
   assign extReset = extResetPinEnable & pinIf.resetReq;
   assign powerOn = ~rst_b | porPulse;
   assign borOn = bor_enabled(brownoutModeCfg, r.swBor, r.sleeping);
   assign borTrip = borOn & brownoutDetect & (r.borCnt >= BOR_MIN_CYC);
   assign addrHit = addr_mapped(avsAddress);
   assign takeReq = (avsRead | avsWrite) & ~r.ack;
   assign doWrite = r.ack & avsWrite & addrHit & (avsAddress == `RCT_OFS_CAUSE_CTRL)
                    & avsByteEnable[0];

   // ==========================================================
   // next state
   always_comb
   begin
      next_r = r;
      next_r.evtReset = 1'b0;

      // bus handshake: one wait cycle, answer on the following edge
      next_r.ack = takeReq;
      if (takeReq)
      begin
         next_r.readData = avsRead ?
            reg_read(avsAddress, r, brownoutModeCfg, borOn, pinIf.pinSync) : 32'h0000_0000;
         next_r.respErr = ~addrHit;
      end

      // software writes to the cause register
      if (doWrite)
      begin
         next_r.irqPrio = avsWriteData[`RCT_BIT_IRQ_PRIO];
         if (brownoutModeCfg == `RCT_BOR_MODE_SW)
         begin
            next_r.swBor = avsWriteData[`RCT_BIT_SW_BOR];
         end
         next_r.softRstFlag = avsWriteData[`RCT_BIT_SOFT_RST];
         next_r.porFlag = avsWriteData[`RCT_BIT_POR];
         next_r.borFlag = avsWriteData[`RCT_BIT_BOR];
      end

      // instruction events on the read-only flags
      if (watchdogClearInstr)
      begin
         next_r.wdtExpFlag = 1'b1;
         next_r.sleepFlag = 1'b1;
      end
      if (sleepInstr)
      begin
         next_r.wdtExpFlag = 1'b1;
         next_r.sleepFlag = 1'b0;
         next_r.sleeping = 1'b1;
      end
      if (wakeUp)
      begin
         next_r.sleeping = 1'b0;
      end

      // brownout minimum duration counter
      if (borOn & brownoutDetect)
      begin
         if (r.borCnt < BOR_MIN_CYC)
         begin
            next_r.borCnt = r.borCnt + `RCT_CNT_W'(1);
         end
      end
      else
      begin
         next_r.borCnt = '0;
      end

      // short resets: pin, watchdog, reset instruction
      if (extReset)
      begin
         next_r.irqPrio = `RCT_RST_IRQ_PRIO;
         next_r.sleeping = 1'b0;
      end
      if (watchdogTimeout)
      begin
         next_r.wdtExpFlag = `RCT_RST_CAUSE_CLR;
         next_r.irqPrio = `RCT_RST_IRQ_PRIO;
         next_r.sleeping = 1'b0;
         next_r.evtReset = 1'b1;
      end
      if (softResetInstr)
      begin
         next_r.softRstFlag = `RCT_RST_CAUSE_CLR;
         next_r.irqPrio = `RCT_RST_IRQ_PRIO;
         next_r.sleeping = 1'b0;
         next_r.evtReset = 1'b1;
      end

      // reset sequencing
      case (r.state)
         rct_pkg::RS_POWERON:
         begin
            if (powerUpTimerEnable)
            begin
               next_r.state = rct_pkg::RS_TIMER;
            end
            else
            begin
               next_r.state = rct_pkg::RS_RUN;
            end
            next_r.pwrtCnt = '0;
         end
         rct_pkg::RS_BROWNOUT:
         begin
            next_r.pwrtCnt = '0;
            if (!brownoutDetect)
            begin
               if (powerUpTimerEnable)
               begin
                  next_r.state = rct_pkg::RS_TIMER;
               end
               else
               begin
                  next_r.state = rct_pkg::RS_RUN;
               end
            end
         end
         rct_pkg::RS_TIMER:
         begin
            if (rcTick)
            begin
               if (r.pwrtCnt == `RCT_POWER_UP_TIMER_W'(POWER_UP_TIMER_TICKS - 1))
               begin
                  next_r.state = rct_pkg::RS_RUN;
               end
               else
               begin
                  next_r.pwrtCnt = r.pwrtCnt + `RCT_POWER_UP_TIMER_W'(1);
               end
            end
         end
         rct_pkg::RS_RUN:
         begin
            next_r.pwrtCnt = '0;
         end
         default:
         begin
            next_r.state = rct_pkg::RS_POWERON;
         end
      endcase

      // brownout trip: detector rearms the RS_BROWNOUT hold
      if (borTrip)
      begin
         next_r.state = rct_pkg::RS_BROWNOUT;
         next_r.pwrtCnt = '0;
         next_r.borFlag = `RCT_RST_CAUSE_CLR;
         next_r.irqPrio = `RCT_RST_IRQ_PRIO;
         next_r.swBor = (brownoutModeCfg == `RCT_BOR_MODE_SW);
         next_r.softRstFlag = `RCT_RST_CAUSE_SET;
         next_r.wdtExpFlag = `RCT_RST_CAUSE_SET;
         next_r.sleepFlag = `RCT_RST_CAUSE_SET;
         next_r.sleeping = 1'b0;
      end

      // power-on: all core state except ack, respErr and readData to its initial value
      if (powerOn)
      begin
         next_r.state = rct_pkg::RS_POWERON;
         next_r.irqPrio = `RCT_RST_IRQ_PRIO;
         next_r.swBor = (brownoutModeCfg == `RCT_BOR_MODE_SW);
         next_r.softRstFlag = `RCT_RST_CAUSE_SET;
         next_r.wdtExpFlag = `RCT_RST_CAUSE_SET;
         next_r.sleepFlag = `RCT_RST_CAUSE_SET;
         next_r.porFlag = `RCT_RST_CAUSE_CLR;
         next_r.borFlag = `RCT_RST_CAUSE_CLR;
         next_r.sleeping = 1'b0;
         next_r.evtReset = 1'b0;
         next_r.borCnt = '0;
         next_r.pwrtCnt = '0;
      end
      if (!rst_b)
      begin
         next_r.ack = 1'b0;
         next_r.respErr = 1'b0;
         next_r.readData = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   // ==========================================================
   // outputs
   assign avsWaitRequest = (avsRead | avsWrite) & ~r.ack;
   assign avsReadData = r.readData;
   assign avsResponse = r.respErr ? 2'h2 : 2'h0;

   assign extResetPinOut = 1'b0;
   assign extResetPinOe = 1'b0;
   assign extResetPinPullup = extResetPinEnable;
   assign extResetPinDigital = extResetPinEnable ? 1'b0 : pinIf.pinSync;

   assign brownoutDetectEnable = borOn;
   assign brownoutLevelSel = brownoutLevelCfg;
   assign irqPriorityEnable = r.irqPrio;
   assign deviceResetActive = (r.state != rct_pkg::RS_RUN) | extReset | r.evtReset;

endmodule : rct_reset_cause_tracking

// file: rct_reset_cause_tracking_properties.sv
`timescale 1ns/1ps

// ==========================================================
// checker on the top module ports
module rct_reset_cause_tracking_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // observed ports
   input wire logic [31:0] avsReadData,
   input wire logic extResetPinIn,
   input wire logic extResetPinOut,
   input wire logic extResetPinOe,
   input wire logic extResetPinPullup,
   input wire logic extResetPinDigital,
   input wire logic extResetPinEnable,
   input wire logic [1:0] brownoutModeCfg,
   input wire logic brownoutDetect,
   input wire logic brownoutDetectEnable,
   input wire logic softResetInstr,
   input wire logic watchdogTimeout,
   input wire logic deviceResetActive,
   input wire logic irqPriorityEnable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_no_drive;
      !extResetPinOe && !extResetPinOut;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("reset pin driven");
   property p_pullup;
      extResetPinPullup == extResetPinEnable;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up wrong");
   property p_bit5;
      !avsReadData[5];
   endproperty
   a_bit5: assert property (p_bit5) else $error("bit 5 set");
   property p_pin_hold;
      (extResetPinEnable && !extResetPinIn) [*8] |-> ##[0:4] deviceResetActive;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin low gave no reset");
   property p_pin_digital;
      (!extResetPinEnable && $stable(extResetPinIn)) [*3] |-> extResetPinDigital == extResetPinIn;
   endproperty
   a_pin_digital: assert property (p_pin_digital) else $error("digital input wrong");
   property p_bor_trip;
      (brownoutModeCfg == 2'h3 && brownoutDetect) [*8] |-> ##[0:3] deviceResetActive;
   endproperty
   a_bor_trip: assert property (p_bor_trip) else $error("brownout gave no reset");
   property p_bor_off;
      brownoutModeCfg == 2'h0 |-> !brownoutDetectEnable;
   endproperty
   a_bor_off: assert property (p_bor_off) else $error("brownout on in mode 00");
   property p_irq_priority_enable_rst;
      $rose(rst_b) |-> !irqPriorityEnable;
   endproperty
   a_irq_priority_enable_rst: assert property (p_irq_priority_enable_rst) else $error("priority not reset");
   property p_soft_rst;
      softResetInstr |=> deviceResetActive;
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("soft reset missing");
   property p_wdt_rst;
      watchdogTimeout |=> deviceResetActive;
   endproperty
   a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missing");
endmodule : rct_reset_cause_tracking_properties

bind rct_reset_cause_tracking rct_reset_cause_tracking_properties rct_props_inst (.*);

// file: rct_supply_model.sv
`timescale 1ns/1ps

// ==========================================================
// pin driver and supply monitors
module rct_supply_model (
   // clock
   input wire logic clk,
   // requests: por, pin low, supply drop
   input wire logic [2:0] req,
   // monitor and pin outputs
   output logic porPulse = 1'b0,
   output logic pinDriveLow = 1'b0,
   output logic brownoutDetect = 1'b0,
   output logic rcTick = 1'b0
);
   logic [1:0] div = 2'h0;

   always_ff @(posedge clk)
   begin
      div <= div + 2'h1;
      rcTick <= (div == 2'h3);
      porPulse <= req[2];
      pinDriveLow <= req[1];
      brownoutDetect <= req[0];
   end
endmodule : rct_supply_model

// file: rct_reset_cause_tracking_bench.sv
`timescale 1ns/1ps
`include "rct_regs.svh"

module rct_reset_cause_tracking_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] avsAddress = 4'h0;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0;
   logic [31:0] avsReadData;
   logic avsWaitRequest;
   logic [1:0] avsResponse;
   logic extResetPinIn, extResetPinOut, extResetPinOe, extResetPinPullup, extResetPinDigital;
   logic [1:0] brownoutModeCfg = 2'h1;
   logic extResetPinEnable = 1'b1;
   logic powerUpTimerEnable = 1'b1;
   logic porPulse, brownoutDetect, brownoutDetectEnable, pinDriveLow, rcTick;
   logic [1:0] brownoutLevelSel;
   logic [4:0] evt = 5'h0;
   logic [2:0] req = 3'h0;
   logic deviceResetActive, irqPriorityEnable;
   logic [31:0] rdData;
   logic [1:0] rdResp;
   int nMismatch = 0;
   int nCompared = 0;

   assign extResetPinIn = extResetPinOe ? extResetPinOut : !pinDriveLow;

   rct_supply_model rct_supply_model_inst (.clk(clk), .req(req), .porPulse(porPulse),
      .pinDriveLow(pinDriveLow), .brownoutDetect(brownoutDetect), .rcTick(rcTick));

   rct_reset_cause_tracking #(.POWER_UP_TIMER_TICKS(8)) rct_reset_cause_tracking_inst (
      .clk(clk), .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse),
      .extResetPinIn(extResetPinIn), .extResetPinOut(extResetPinOut),
      .extResetPinOe(extResetPinOe), .extResetPinPullup(extResetPinPullup),
      .extResetPinDigital(extResetPinDigital), .brownoutModeCfg(brownoutModeCfg),
      .brownoutLevelCfg(2'h2), .extResetPinEnable(extResetPinEnable),
      .powerUpTimerEnable(powerUpTimerEnable), .porPulse(porPulse),
      .brownoutDetect(brownoutDetect), .brownoutDetectEnable(brownoutDetectEnable),
      .brownoutLevelSel(brownoutLevelSel), .softResetInstr(evt[4]),
      .watchdogClearInstr(evt[3]), .sleepInstr(evt[2]), .watchdogTimeout(evt[1]),
      .wakeUp(evt[0]), .rcTick(rcTick), .deviceResetActive(deviceResetActive),
      .irqPriorityEnable(irqPriorityEnable));

   // ==========================================================
   // clock and tasks
   initial
   begin
      forever #20 clk = ~clk;
   end

   task automatic conclude;
      if (nMismatch == 0 && nCompared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWriteData <= d;
      do
      begin
         @(posedge clk);
      end
      while (avsWaitRequest !== 1'b0);
      rdData = avsReadData;
      rdResp = avsResponse;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdData, e);
   endtask : rd

   task automatic settle;
      int k;
      k = 0;
      while (deviceResetActive !== 1'b0 && k < 300)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 300)
         nMismatch++;
      repeat (2) @(posedge clk);
   endtask : settle

   task automatic ev(input logic [4:0] m);
      @(posedge clk);
      evt <= m;
      @(posedge clk);
      evt <= 5'h0;
      repeat (2) @(posedge clk);
      settle();
   endtask : ev

   task automatic drive(input logic [2:0] m, input int n, input logic e);
      logic hit;
      hit = 1'b0;
      @(posedge clk);
      req <= m;
      repeat (n)
      begin
         @(posedge clk);
         hit = hit | deviceResetActive;
      end
      req <= 3'h0;
      repeat (10)
      begin
         @(posedge clk);
         hit = hit | deviceResetActive;
      end
      chk({31'h0, hit}, {31'h0, e});
      settle();
   endtask : drive

   // ==========================================================
   // watchdog
   initial
   begin
      repeat (8000) @(posedge clk);
      nMismatch++;
      conclude();
   end

   // ==========================================================
   // tests
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      settle();
      rd(`RCT_OFS_CAUSE_CTRL, 32'h5C);
      bus(1'b1, `RCT_OFS_CAUSE_CTRL, 32'hFF);
      rd(`RCT_OFS_CAUSE_CTRL, 32'hDF);
      chk({31'h0, irqPriorityEnable}, 32'h1);
      bus(1'b1, `RCT_OFS_CAUSE_CTRL, 32'h00);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h0C);
      chk({31'h0, brownoutDetectEnable}, 32'h0);
      bus(1'b1, `RCT_OFS_CAUSE_CTRL, 32'h5F);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h5F);
      chk({31'h0, brownoutDetectEnable}, 32'h1);
      ev(5'h04);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h5B);
      ev(5'h08);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h5F);
      ev(5'h02);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h57);
      ev(5'h08);
      ev(5'h10);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h4F);
      bus(1'b1, `RCT_OFS_CAUSE_CTRL, 32'h5F);
      drive(3'h2, 3, 1'b0);
      drive(3'h2, 20, 1'b1);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h5F);
      extResetPinEnable <= 1'b0;
      drive(3'h2, 20, 1'b0);
      chk({31'h0, extResetPinDigital}, 32'h1);
      extResetPinEnable <= 1'b1;
      brownoutModeCfg <= 2'h3;
      rd(`RCT_OFS_CAUSE_CTRL, 32'h1F);
      drive(3'h1, 4, 1'b0);
      drive(3'h1, 20, 1'b1);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h1E);
      brownoutModeCfg <= 2'h0;
      drive(3'h1, 20, 1'b0);
      brownoutModeCfg <= 2'h2;
      repeat (2) @(posedge clk);
      chk({31'h0, brownoutDetectEnable}, 32'h1);
      ev(5'h04);
      chk({31'h0, brownoutDetectEnable}, 32'h0);
      ev(5'h01);
      chk({31'h0, brownoutDetectEnable}, 32'h1);
      drive(3'h4, 3, 1'b1);
      rd(`RCT_OFS_CAUSE_CTRL, 32'h1C);
      powerUpTimerEnable <= 1'b0;
      req <= 3'h4;
      repeat (4) @(posedge clk);
      req <= 3'h0;
      repeat (6) @(posedge clk);
      chk({31'h0, deviceResetActive}, 32'h0);
      rd(`RCT_OFS_STATUS, 32'h5);
      chk({30'h0, brownoutLevelSel}, 32'h2);
      rd(4'h8, 32'h0);
      chk({30'h0, rdResp}, 32'h2);
      conclude();
   end
endmodule : rct_reset_cause_tracking_bench
